//--- twi_write_pkg.sv
/*
  Shared constants and types for the two-wire management write target.
  Assumes a 50 MHz system clock and an 8-bit memory address space.
*/
package twi_write_pkg;

  // Clock and internal write cycle timing
  localparam int unsigned CLOCK_PERIOD_NS = 20;
  localparam int unsigned INTERNAL_WRITE_CYCLE_TIME_NS = 10000000;
  // Least time, rounded up to whole cycles
  localparam int unsigned INTERNAL_WRITE_CYCLE_COUNT =
    (INTERNAL_WRITE_CYCLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Bus addressing
  localparam logic [7:0] DEV_ADDR_WRITE   = 8'ha0;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [2:0] MAX_SEQ_BYTES    = 3'h4;

  // Memory map: page and bank selection in lower memory
  localparam logic [7:0] BANK_SELECT_ADDR = 8'h7e;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'h7f;
  localparam logic [7:0] UPPER_BASE       = 8'h80;
  localparam logic [7:0] PAGE_LANE_ADVERT = 8'h06;
  localparam logic [7:0] PAGE_LANE_CTRL   = 8'h1a;
  localparam logic [7:0] LANES_PER_BANK   = 8'h08;

  // Values after reset
  localparam logic [7:0] PAGE_RESET       = 8'h00;
  localparam logic [7:0] BANK_RESET       = 8'h00;

  // Memory write word layout
  localparam int unsigned WORD_W          = 32;
  localparam int unsigned WORD_DATA_LSB   = 0;
  localparam int unsigned WORD_ADDR_LSB   = 8;
  localparam int unsigned WORD_PAGE_LSB   = 16;
  localparam int unsigned WORD_BANK_LSB   = 24;
  localparam int unsigned BUF_DEPTH       = 2;

  // Target states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_RECV   = 6'h02,
    ST_ACK    = 6'h04,
    ST_SKIP   = 6'h08,
    ST_COMMIT = 6'h10,
    ST_BUSY   = 6'h20
  } twi_state_type;

  // Which byte of the transaction is being received
  typedef enum logic [2:0] {
    STG_DEV  = 3'h1,
    STG_MEM  = 3'h2,
    STG_DATA = 3'h4
  } byte_stage_type;

endpackage

//--- word_path_if.sv
/*
  Fill side of the memory write buffer: one word with valid and ready.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface word_path_if;
  logic                              valid; // Word offered
  logic                              ready; // Buffer can take it
  logic [twi_write_pkg::WORD_W-1:0]  data;  // Packed write word

  // Producer of words
  modport feed (output valid, output data, input ready);
  // Buffer taking words
  modport take (input valid, input data, output ready);
endinterface

//--- pin_sync.sv
/*
  Two-stage synchroniser for asynchronous pin levels.
  Assumes pins may change at any time relative to clock.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clocking
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             ce,
  // Levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_r
);

  // Both stages in one state word
  typedef struct packed {
    logic [WIDTH-1:0] first;  // Only read by the second stage
    logic [WIDTH-1:0] second; // Stable copy
  } sync_type;

  sync_type r, n;

  // Next state: shift the pins through
  always_comb
  begin
    n        = r;
    n.first  = pin_in;
    n.second = r.first;
  end

  // Register, idle level of the bus is high
  always_ff @(posedge clock)
  begin
    if (reset)
      r <= '{first: '1, second: '1};
    else if (ce)
      r <= n;
  end

  assign pin_sync_r = r.second;

endmodule

//--- word_buffer.sv
/*
  Small shift queue between write staging and internal memory.
  Assumes the drain side may hold ready low for any time.
*/
`timescale 1ns/1ns
module word_buffer #(
  parameter int unsigned WIDTH = twi_write_pkg::WORD_W,
  parameter int unsigned DEPTH = twi_write_pkg::BUF_DEPTH
) (
  // Clocking
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             ce,
  // Fill side
  word_path_if.take             fill,
  // Drain side
  output logic                  out_valid_r,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data_r
);

  // Entries and their valid flags; entry 0 is the head
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] entry;
    logic [DEPTH-1:0]            full;
  } queue_type;

  queue_type r, n;
  logic      pop;  // Head leaves this cycle
  logic      push; // Word enters this cycle

  assign pop  = r.full[0] & out_ready;
  assign push = fill.valid & ~r.full[DEPTH-1];

  // Shift down on pop, then place a new word in the first free slot
  always_comb
  begin
    n = r;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        n.entry[i] = r.entry[i+1];
        n.full[i]  = r.full[i+1];
      end
      n.full[DEPTH-1] = 1'b0;
    end
    if (push)
    begin
      for (int i = DEPTH - 1; i >= 0; i--)
      begin
        // Lowest empty slot wins
        if (!n.full[i] && (i == 0 || n.full[i-1]))
        begin
          n.entry[i] = fill.data;
          n.full[i]  = 1'b1;
        end
      end
    end
  end

  // Register the queue
  always_ff @(posedge clock)
  begin
    if (reset)
      r <= '0;
    else if (ce)
      r <= n;
  end

  // Ready only while the last slot is free, stalls the producer
  assign fill.ready  = ~r.full[DEPTH-1];
  assign out_valid_r = r.full[0];
  assign out_data_r  = r.entry[0];

endmodule

//--- mgmt_twi_sequential_write.sv
/*
  Two-wire management target, write path with sequential writes,
  timed internal write cycle, acknowledge polling and page/bank select.
  Assumes a host master drives the serial clock and never stretches it;
  the data pin is open drain and pulled high outside.
*/
`timescale 1ns/1ns
module mgmt_twi_sequential_write #(
  parameter int unsigned WRITE_CYCLES =
    twi_write_pkg::INTERNAL_WRITE_CYCLE_COUNT
) (
  // Clocking
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       ce,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Internal memory write port
  output logic            mem_wr_valid,
  input  wire logic       mem_wr_ready,
  output logic      [7:0] mem_wr_bank,
  output logic      [7:0] mem_wr_page,
  output logic      [7:0] mem_wr_addr,
  output logic      [7:0] mem_wr_data,
  // Status
  output logic            write_busy,
  output logic      [7:0] page_select,
  output logic      [7:0] bank_select,
  output logic      [7:0] lane_base
);

  // Whole state of the target
  typedef struct packed {
    twi_write_pkg::twi_state_type  state;    // Bus state
    twi_write_pkg::byte_stage_type stage;    // Byte being received
    logic                          scl_p;    // Last stable clock
    logic                          sda_p;    // Last stable data
    logic [7:0]                    shift;    // Incoming bits
    logic [3:0]                    bitcnt;   // Bits of this byte
    logic [7:0]                    addr;     // Start memory address
    logic [2:0]                    cnt;      // Staged byte count
    logic [1:0]                    idx;      // Commit index
    logic [3:0][7:0]               stash;    // Staged data bytes
    logic [31:0]                   timer;    // Write cycle timer
    logic [7:0]                    page;     // Selected upper page
    logic [7:0]                    bank;     // Selected lane bank
    logic [7:0]                    lane_base; // First lane of bank
    logic                          busy;     // Write in progress
    logic                          sda_oe_n; // Low while pulling
    logic                          sda_out;  // Driven level
  } core_type;

  core_type    r, n;
  logic [1:0]  pins_s;    // Synchronised clock and data
  logic        scl_s;     // Stable clock level
  logic        sda_s;     // Stable data level
  logic        start_ev;  // START seen
  logic        stop_ev;   // STOP seen
  logic        scl_rise;  // Clock rising
  logic        scl_fall;  // Clock falling
  logic [7:0]  wr_addr;   // Address of word being committed
  logic [7:0]  wr_data;   // Data of word being committed
  logic        wr_upper;  // Word lands in upper memory
  logic [31:0] buf_word;  // Buffer head word

  word_path_if wpath ();

  // Pin synchroniser
  pin_sync #(
    .WIDTH      (2)
  ) u_sync (
    .clock      (clock),
    .reset      (reset),
    .ce         (ce),
    .pin_in     ({scl_in, sda_in}),
    .pin_sync_r (pins_s)
  );

  // Write buffer towards internal memory
  word_buffer #(
    .WIDTH       (twi_write_pkg::WORD_W),
    .DEPTH       (twi_write_pkg::BUF_DEPTH)
  ) u_buffer (
    .clock       (clock),
    .reset       (reset),
    .ce          (ce),
    .fill        (wpath.take),
    .out_valid_r (mem_wr_valid),
    .out_ready   (mem_wr_ready),
    .out_data_r  (buf_word)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Bus conditions from stable levels
  assign start_ev = scl_s & r.scl_p & r.sda_p & ~sda_s;
  assign stop_ev  = scl_s & r.scl_p & ~r.sda_p & sda_s;
  assign scl_rise = scl_s & ~r.scl_p;
  assign scl_fall = ~scl_s & r.scl_p;

  assign wr_addr  = r.addr + {6'h0, r.idx};
  assign wr_data  = r.stash[r.idx];
  assign wr_upper = wr_addr >= twi_write_pkg::UPPER_BASE;

  // Word for the buffer: bank, page, address, data
  always_comb
  begin
    wpath.valid = (r.state == twi_write_pkg::ST_COMMIT);
    wpath.data  = '0;
    wpath.data[twi_write_pkg::WORD_DATA_LSB +: 8] = wr_data;
    wpath.data[twi_write_pkg::WORD_ADDR_LSB +: 8] = wr_addr;
    if (wr_upper)
      wpath.data[twi_write_pkg::WORD_PAGE_LSB +: 8] = r.page;
    if (wr_upper && r.page == twi_write_pkg::PAGE_LANE_CTRL)
      wpath.data[twi_write_pkg::WORD_BANK_LSB +: 8] = r.bank;
  end

  // Next state of the target
  always_comb
  begin
    n       = r;
    n.scl_p = scl_s;
    n.sda_p = sda_s;
    unique case (r.state)
      // Push staged bytes one per cycle, buffer stalls us
      twi_write_pkg::ST_COMMIT:
      begin
        if (wpath.ready)
        begin
          if (!wr_upper && wr_addr == twi_write_pkg::PAGE_SELECT_ADDR)
            n.page = wr_data;
          if (!wr_upper && wr_addr == twi_write_pkg::BANK_SELECT_ADDR)
          begin
            n.bank      = wr_data;
            n.lane_base = 8'(wr_data * twi_write_pkg::LANES_PER_BANK);
          end
          n.idx = r.idx + 2'h1;
          if ({1'b0, r.idx} == 3'(r.cnt - 3'h1))
          begin
            n.state = twi_write_pkg::ST_BUSY;
            n.timer = '0;
          end
        end
      end
      // pins not looked at while timing
      twi_write_pkg::ST_BUSY:
      begin
        n.timer = r.timer + 32'h1;
        if (r.timer >= 32'(WRITE_CYCLES - 1) && !mem_wr_valid)
        begin
          n.state = twi_write_pkg::ST_IDLE;
          n.busy  = 1'b0;
        end
      end
      // Bus facing states
      twi_write_pkg::ST_IDLE, twi_write_pkg::ST_RECV,
      twi_write_pkg::ST_ACK, twi_write_pkg::ST_SKIP:
      begin
        if (start_ev)
        begin
          n.state    = twi_write_pkg::ST_RECV;
          n.stage    = twi_write_pkg::STG_DEV;
          n.bitcnt   = 4'h0;
          n.cnt      = 3'h0;
          n.sda_oe_n = 1'b1;
        end
        else if (stop_ev)
        begin
          n.sda_oe_n = 1'b1;
          if (r.state != twi_write_pkg::ST_IDLE && r.cnt != 3'h0)
          begin
            n.state = twi_write_pkg::ST_COMMIT;
            n.idx   = 2'h0;
            n.busy  = 1'b1;
          end
          else
            n.state = twi_write_pkg::ST_IDLE;
        end
        else if (r.state == twi_write_pkg::ST_RECV)
        begin
          if (scl_rise)
          begin
            // Sample data on rising clock
            n.shift  = {r.shift[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          else if (scl_fall && r.bitcnt == twi_write_pkg::BITS_PER_BYTE)
          begin
            // Byte complete, decide acknowledge
            n.bitcnt = 4'h0;
            unique case (r.stage)
              twi_write_pkg::STG_DEV:
              begin
                if (r.shift == twi_write_pkg::DEV_ADDR_WRITE)
                begin
                  n.state    = twi_write_pkg::ST_ACK;
                  n.stage    = twi_write_pkg::STG_MEM;
                  n.sda_oe_n = 1'b0;
                end
                else
                  // Not ours or a read, stay off the bus
                  n.state = twi_write_pkg::ST_SKIP;
              end
              twi_write_pkg::STG_MEM:
              begin
                n.addr     = r.shift;
                n.state    = twi_write_pkg::ST_ACK;
                n.stage    = twi_write_pkg::STG_DATA;
                n.sda_oe_n = 1'b0;
              end
              twi_write_pkg::STG_DATA:
              begin
                if (r.cnt < twi_write_pkg::MAX_SEQ_BYTES)
                begin
                  n.stash[r.cnt[1:0]] = r.shift;
                  n.cnt               = r.cnt + 3'h1;
                  n.state             = twi_write_pkg::ST_ACK;
                  n.sda_oe_n          = 1'b0;
                end
                else
                  n.state = twi_write_pkg::ST_SKIP;
              end
              default:
                n.state = twi_write_pkg::ST_SKIP;
            endcase
          end
        end
        else if (r.state == twi_write_pkg::ST_ACK && scl_fall)
        begin
          // Release after the acknowledge clock
          n.sda_oe_n = 1'b1;
          n.state    = twi_write_pkg::ST_RECV;
        end
      end
      default:
        n.state = twi_write_pkg::ST_IDLE;
    endcase
  end

  // Register the whole state
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      r           <= '0;
      r.state     <= twi_write_pkg::ST_IDLE;
      r.stage     <= twi_write_pkg::STG_DEV;
      r.scl_p     <= 1'b1;
      r.sda_p     <= 1'b1;
      r.page      <= twi_write_pkg::PAGE_RESET;
      r.bank      <= twi_write_pkg::BANK_RESET;
      r.sda_oe_n  <= 1'b1;
    end
    else if (ce)
      r <= n;
  end

  // Outputs straight from flip-flops
  assign sda_out     = r.sda_out;
  assign sda_oe_n    = r.sda_oe_n;
  assign write_busy  = r.busy;
  assign page_select = r.page;
  assign bank_select = r.bank;
  assign lane_base   = r.lane_base;
  assign mem_wr_bank = buf_word[twi_write_pkg::WORD_BANK_LSB +: 8];
  assign mem_wr_page = buf_word[twi_write_pkg::WORD_PAGE_LSB +: 8];
  assign mem_wr_addr = buf_word[twi_write_pkg::WORD_ADDR_LSB +: 8];
  assign mem_wr_data = buf_word[twi_write_pkg::WORD_DATA_LSB +: 8];

endmodule

//--- twi_write_props.sv
/*
  Port checker for the two-wire write target.
  Assumes one clock domain and a synchronous reset.
*/
`timescale 1ns/1ns
module twi_write_props #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  // Clocking
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       ce,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Memory port
  input wire logic       mem_wr_valid,
  input wire logic       mem_wr_ready,
  input wire logic [7:0] mem_wr_bank,
  input wire logic [7:0] mem_wr_page,
  input wire logic [7:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  // Status
  input wire logic       write_busy,
  input wire logic [7:0] page_select,
  input wire logic [7:0] bank_select,
  input wire logic [7:0] lane_base
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] busy_cnt_r; // Cycles spent busy

  // Counts the length of a write cycle
  always_ff @(posedge clock)
  begin
    if (reset || !write_busy)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy_cnt_r + 32'h1;
  end

  AST_QUIET_BUSY: assert property (write_busy |-> sda_oe_n)
    else $error("ack during write cycle");
  AST_ACK_EDGE: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("ack moved while clock high");
  AST_ACK_LOW: assert property (!sda_oe_n |-> !sda_out)
    else $error("ack not low");
  AST_VALID_BUSY: assert property (mem_wr_valid |-> write_busy)
    else $error("word outside write cycle");
  AST_FIRST_WORD: assert property ($rose(write_busy) |->
    ##[1:2] mem_wr_valid)
    else $error("no word after stop");
  AST_HOLD_WORD: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable({mem_wr_bank, mem_wr_page, mem_wr_addr,
    mem_wr_data}))
    else $error("stalled word changed");
  AST_ADDR_STEP: assert property (mem_wr_valid && mem_wr_ready && ce
    ##1 mem_wr_valid |-> mem_wr_addr == $past(mem_wr_addr) + 8'h01)
    else $error("address did not step");
  AST_LOWER_FLAT: assert property (mem_wr_valid && !mem_wr_addr[7] |->
    {mem_wr_bank, mem_wr_page} == 16'h0)
    else $error("lower word paged");
  AST_BANK_GATE: assert property (mem_wr_valid &&
    mem_wr_page != twi_write_pkg::PAGE_LANE_CTRL |-> mem_wr_bank == 8'h00)
    else $error("bank off lane page");
  AST_LANE_BASE: assert property (lane_base == {bank_select[4:0], 3'h0})
    else $error("lane base wrong");
  AST_PAGE_SET: assert property (mem_wr_valid &&
    mem_wr_addr == twi_write_pkg::PAGE_SELECT_ADDR |->
    page_select == mem_wr_data)
    else $error("page select stale");
  AST_CYCLE_LEN: assert property ($fell(write_busy) |->
    busy_cnt_r >= WRITE_CYCLES)
    else $error("write cycle too short");
endmodule

bind mgmt_twi_sequential_write twi_write_props #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_props (
  .clock(clock), .reset(reset), .ce(ce), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
  .mem_wr_bank(mem_wr_bank), .mem_wr_page(mem_wr_page),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
  .write_busy(write_busy), .page_select(page_select),
  .bank_select(bank_select), .lane_base(lane_base)
);

//--- twi_host_model.sv
/*
  Host master model driving the two-wire clock and data.
  Assumes an open-drain data line pulled high outside.
*/
`timescale 1ns/1ns
module twi_host_model #(
  parameter int P = 6
) (
  // Clocking
  input  wire logic clock,
  // Pins
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic drv = 1'b1; // Host data drive, high releases
  initial scl = 1'b1;
  // Wired-and with pull-up
  assign sda = drv & sda_oe_n;

  // Waits cycles, then steps off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // Data change while clock high
  task automatic cond(input logic a, input logic b);
    drv = a;
    hold(P);
    scl = 1'b1;
    hold(P);
    drv = b;
    hold(P);
  endtask
  // One clock pulse, data sampled mid-high
  task automatic pulse(output logic s);
    hold(P);
    scl = 1'b1;
    hold(P / 2);
    s = sda;
    hold(P - P / 2);
    scl = 1'b0;
  endtask
  // Byte MSB first, returns the ninth-bit level
  task automatic put_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      drv = b[i];
      pulse(s);
    end
    drv = 1'b1;
    pulse(nak);
  endtask
  // Write transaction, stop optional
  task automatic txn(input logic [7:0] mem, input logic [7:0] d[$],
                     input bit fin, output logic [7:0] naks);
    naks = 8'hff;
    cond(1'b1, 1'b0);
    scl = 1'b0;
    put_byte(twi_write_pkg::DEV_ADDR_WRITE, naks[0]);
    put_byte(mem, naks[1]);
    foreach (d[k]) put_byte(d[k], naks[k + 2]);
    if (fin)
      cond(1'b0, 1'b1);
  endtask
  task automatic poll(output logic nak);
    probe(twi_write_pkg::DEV_ADDR_WRITE, nak);
  endtask
  // Start, one address byte, stop
  task automatic probe(input logic [7:0] dev, output logic nak);
    cond(1'b1, 1'b0);
    scl = 1'b0;
    put_byte(dev, nak);
    cond(1'b0, 1'b1);
  endtask
endmodule

//--- tb.sv
/*
  Self-checking bench for the write target.
  Assumes the host model and a stalling memory port.
*/
`timescale 1ns/1ns
module tb;
  localparam int WC = 200; // Shortened write cycle
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        mem_wr_ready = 1'b0;
  logic        scl, sda, sda_out, sda_oe_n, mem_wr_valid, write_busy;
  logic [7:0]  mem_wr_bank, mem_wr_page, mem_wr_addr, mem_wr_data;
  logic [7:0]  page_select, bank_select, lane_base;
  logic [31:0] got[$], exp[$]; // Seen and expected words
  logic [7:0]  pg = 8'h00;     // Expected page select
  logic [7:0]  bk = 8'h00;     // Expected bank select
  int          bad_count = 0;
  int          n_checks = 0;

  always #10 clock = ~clock;

  mgmt_twi_sequential_write #(.WRITE_CYCLES(WC)) u_dut (
    .clock(clock), .reset(reset), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_bank(mem_wr_bank),
    .mem_wr_page(mem_wr_page), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .write_busy(write_busy),
    .page_select(page_select), .bank_select(bank_select),
    .lane_base(lane_base));
  twi_host_model u_host (.clock(clock), .sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));

  // Memory mostly stalls, so the buffer fills
  always @(posedge clock)
    #2 mem_wr_ready = ($urandom % 4) == 0;
  // Word taken at the next edge
  always @(negedge clock)
    if (mem_wr_valid && mem_wr_ready && ce)
      got.push_back({mem_wr_bank, mem_wr_page, mem_wr_addr, mem_wr_data});

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Expected word for one byte
  function automatic logic [31:0] word(input logic [7:0] a,
                                       input logic [7:0] d);
    logic [7:0] p;
    p = a[7] ? pg : 8'h00;
    return {(p == twi_write_pkg::PAGE_LANE_CTRL) ? bk : 8'h00, p, a, d};
  endfunction
  // One transaction with its expected words
  task automatic wr(input logic [7:0] mem, input logic [7:0] d[$],
                    input bit fin);
    logic [7:0] naks;
    logic [7:0] a;
    u_host.txn(mem, d, fin, naks);
    check(naks[1:0] === 2'b00, "address ack");
    foreach (d[k]) check(naks[k + 2] === (k > 3), "data ack");
    for (int k = 0; fin && k < d.size() && k < 4; k++)
    begin
      a = 8'(mem + k);
      exp.push_back(word(a, d[k]));
      pg = (a == twi_write_pkg::PAGE_SELECT_ADDR) ? d[k] : pg;
      bk = (a == twi_write_pkg::BANK_SELECT_ADDR) ? d[k] : bk;
    end
  endtask
  // Wait out the cycle, then compare words
  task automatic settle();
    int i;
    for (i = 0; i < 4000 && (write_busy !== 1'b0); i++)
      @(posedge clock);
    if (i == 4000)
    begin
      check(1'b0, "write cycle timeout");
      finish_test();
    end
    check(got.size() == exp.size(), "word count");
    foreach (exp[k]) check(got[k] === exp[k], "word");
    got.delete();
    exp.delete();
  endtask

  initial
  begin
    logic [7:0] d[$];
    logic       nk;
    int         t;
    void'($urandom(19502));
    repeat (20) @(posedge clock);
    #2 reset = 1'b0;
    repeat (4) @(posedge clock);
    check({write_busy, mem_wr_valid, sda_oe_n} === 3'b001, "idle");
    // Random writes of one to four bytes, one wrapping
    for (int n = 0; n < 8; n++)
    begin
      d.delete();
      repeat (n % 4 + 1) d.push_back(8'($urandom));
      t = $urandom_range(255, 0);
      t = (t inside {[120:127]}) ? 16 : ((n == 3) ? 254 : t);
      wr(8'(t), d, 1'b1);
      settle();
    end
    // Bank and both added pages, then an upper write
    for (int j = 0; j < 2; j++)
    begin
      d = '{8'($urandom_range(31, 0)), (j != 0) ? 8'h06 : 8'h1a};
      wr(8'h7e, d, 1'b1);
      settle();
      check(lane_base === 8'({bk, 3'h0}) && bank_select === bk, "bank");
      check(page_select === pg, "page");
      d = '{8'($urandom)};
      wr(8'($urandom_range(255, 128)), d, 1'b1);
      settle();
    end
    // Fifth byte refused, four kept
    d = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
    wr(8'h20, d, 1'b1);
    settle();
    // Repeated start drops the staged bytes
    d = '{8'h11, 8'h22};
    wr(8'h30, d, 1'b0);
    d = '{8'h33};
    wr(8'h40, d, 1'b1);
    settle();
    // Read address refused, empty write starts no cycle
    u_host.probe(twi_write_pkg::DEV_ADDR_WRITE | 8'h01, nk);
    check(nk === 1'b1 && write_busy === 1'b0, "read address");
    d.delete();
    wr(8'h70, d, 1'b1);
    check(write_busy === 1'b0, "empty write");
    // Enable low freezes the write cycle and the memory port
    d = '{8'($urandom)};
    wr(8'h60, d, 1'b1);
    ce = 1'b0;
    repeat (300) @(posedge clock);
    check(write_busy === 1'b1, "frozen by enable");
    #2 ce = 1'b1;
    settle();
    // Polling refused during the cycle, then accepted
    d = '{8'($urandom)};
    wr(8'h50, d, 1'b1);
    u_host.poll(nk);
    check(nk === 1'b1, "poll during cycle");
    for (t = 0; t < 10 && nk; t++)
      u_host.poll(nk);
    check(nk === 1'b0 && write_busy === 1'b0, "poll after cycle");
    settle();
    finish_test();
  end
endmodule
